// File: shared/atf_pkg.sv
// package: task-file register map, field positions and shared carriers
package atf_pkg;

  // ==========================================================================
  // address decode: {cs2, cs1, da2, da1, da0}
  localparam logic [4:0] ADDR_DATA     = 5'h10;
  localparam logic [4:0] ADDR_FEAT_ERR = 5'h11;
  localparam logic [4:0] ADDR_INTR     = 5'h12;
  localparam logic [4:0] ADDR_SECT     = 5'h13;
  localparam logic [4:0] ADDR_BCL      = 5'h14;
  localparam logic [4:0] ADDR_BCH      = 5'h15;
  localparam logic [4:0] ADDR_DRVSEL   = 5'h16;
  localparam logic [4:0] ADDR_CMD_STAT = 5'h17;
  localparam logic [4:0] ADDR_DCTL_ALT = 5'h0e;
  localparam logic [4:0] ADDR_DRVADR   = 5'h0f;

  // ==========================================================================
  // field positions and codes
  localparam int unsigned DRV_BIT_POS  = 4;
  localparam int unsigned BUSY_BIT_POS = 7;
  localparam int unsigned SOFT_RESET_BIT_BIT_POS = 2;
  localparam int unsigned HOST_IRQ_DISABLE_BIT_POS = 1;
  localparam int unsigned HIZ_BIT_POS  = 7;
  localparam logic [7:0]  CMD_DIAG     = 8'h90;
  localparam logic [7:0]  DRVSEL_FIXED = 8'he0;
  localparam logic [7:0]  DRVSEL_KEEP  = 8'h1f;
  localparam logic [7:0]  STATUS_RST   = 8'h80;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [15:0] WORD_ZERO    = 16'h0000;
  localparam logic [15:0] OE_BYTE      = 16'h00ff;
  localparam logic [15:0] OE_WORD      = 16'hffff;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       cs1;
    logic       cs2;
    logic [2:0] da;
    logic       rd;
    logic       wr;
    logic [15:0] wdata;
  } atf_host_req_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic [15:0] rdata_oe;
  } atf_host_rsp_t;

  // sub-cpu side view of the shared registers
  typedef struct packed {
    logic [15:0] data;
    logic [7:0]  error_report;
    logic [7:0]  interrupt_reason;
    logic [7:0]  sector_count;
    logic [7:0]  byte_count_low;
    logic [7:0]  byte_count_high;
    logic [7:0]  status;
    logic [7:0]  drive_address;
  } atf_cpu_regs_t;

endpackage : atf_pkg

// File: rtl/atf_host_decode.sv
// module: host chip-select and address decode into one-hot register selects
`timescale 1ns/1ps
`default_nettype none
module atf_host_decode
(
  input  wire logic [4:0] i_addr,
  output logic            o_data,
  output logic            o_feat_err,
  output logic            o_intr,
  output logic            o_sect,
  output logic            o_bcl,
  output logic            o_bch,
  output logic            o_drvsel,
  output logic            o_cmd_stat,
  output logic            o_dctl_alt,
  output logic            o_drvadr
);

  always_comb
  begin
    o_data     = (i_addr == atf_pkg::ADDR_DATA);
    o_feat_err = (i_addr == atf_pkg::ADDR_FEAT_ERR);
    o_intr     = (i_addr == atf_pkg::ADDR_INTR);
    o_sect     = (i_addr == atf_pkg::ADDR_SECT);
    o_bcl      = (i_addr == atf_pkg::ADDR_BCL);
    o_bch      = (i_addr == atf_pkg::ADDR_BCH);
    o_drvsel   = (i_addr == atf_pkg::ADDR_DRVSEL);
    o_cmd_stat = (i_addr == atf_pkg::ADDR_CMD_STAT);
    o_dctl_alt = (i_addr == atf_pkg::ADDR_DCTL_ALT);
    o_drvadr   = (i_addr == atf_pkg::ADDR_DRVADR);
  end

endmodule : atf_host_decode
`default_nettype wire

// File: rtl/atf_irq_pin.sv
// module: host interrupt pin drive, tri-state output enable
`timescale 1ns/1ps
`default_nettype none
module atf_irq_pin
(
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_pending,
  input  wire logic i_disable,
  input  wire logic i_selected,
  output logic      o_irq_out,
  output logic      o_irq_oe
);

  logic irq_out_reg;
  logic irq_oe_reg;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      irq_out_reg <= 1'b0;
      irq_oe_reg  <= 1'b0;
    end
    else
    begin
      irq_out_reg <= i_pending;
      // driven only when enabled and selected, else high impedance
      irq_oe_reg  <= ~i_disable & i_selected;
    end
  end

  assign o_irq_out = irq_out_reg;
  assign o_irq_oe  = irq_oe_reg;

endmodule : atf_irq_pin
`default_nettype wire

// File: rtl/atf_task_file.sv
// module: host-facing packet-interface task-file register set
//
// Contract
// - The data port is a 16-bit register carrying data both ways between host and device.
// - The device is selected when drive-select bit 4 equals the own drive number from the sub-cpu.
// - A command write while selected raises the command-arrival interrupt to the sub-cpu.
// - A write of the diagnostic command code raises that interrupt even when not selected.
// - Any command register write clears a pending host interrupt, unless a selected sub-cpu request sets it in the same cycle.
// - Status bit 7 is busy, set by selected command, diagnostic, soft reset and hardware reset.
// - Alternate status reads the same as status but leaves the host interrupt asserted.
// - Reading the drive-address register leaves bus bit 7 undriven.
// - Writing soft reset high raises the soft-reset interrupt and sets busy.
// - The host interrupt pin is driven only when the disable bit is 0 and the drive is selected.
// - The pin is high impedance when the disable bit is 1 or the drive is not selected.
// - Registers decode from two chip selects and three address lines, data 16 bits, others 8.
// - Host registers share contents with the sub-cpu registers of the same name.
`timescale 1ns/1ps
`default_nettype none
module atf_task_file
(
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst,
  input  wire atf_pkg::atf_host_req_t  i_host,
  output atf_pkg::atf_host_rsp_t       o_host,
  output logic                         o_irq_out,
  output logic                         o_irq_oe,
  input  wire logic                    i_own_drive_number,
  input  wire logic                    i_cpu_wr,
  input  wire atf_pkg::atf_cpu_regs_t  i_cpu_regs,
  input  wire logic                    i_cpu_irq_set,
  input  wire logic                    i_cpu_busy_clr,
  output atf_pkg::atf_cpu_regs_t       o_cpu_regs,
  output logic [7:0]                   o_feature_code,
  output logic [7:0]                   o_command_entry,
  output logic [7:0]                   o_drive_selector,
  output logic [7:0]                   o_device_control,
  output logic                         o_command_arrival_irq,
  output logic                         o_soft_reset_irq,
  output logic                         o_data_wr_pulse,
  output logic                         o_data_rd_pulse
);

  // ==========================================================================
  // state
  typedef struct packed {
    atf_pkg::atf_cpu_regs_t shared;
    logic [7:0]             feature_code;
    logic [7:0]             command_entry;
    logic [7:0]             drive_selector;
    logic [7:0]             device_control;
    logic                   irq_pending;
    logic                   cmd_irq;
    logic                   soft_reset_bit_irq;
    logic                   data_wr;
    logic                   data_rd;
    logic                   rd_prev;
    logic                   wr_prev;
    atf_pkg::atf_host_rsp_t rsp;
  } atf_state_t;

  atf_state_t st_reg;
  atf_state_t st_next;

  logic s_data;
  logic s_feat_err;
  logic s_intr;
  logic s_sect;
  logic s_bcl;
  logic s_bch;
  logic s_drvsel;
  logic s_cmd_stat;
  logic s_dctl_alt;
  logic s_drvadr;
  logic selected;
  logic wr_evt;
  logic rd_evt;
  logic host_cs;
  logic cmd_accept;

  // ==========================================================================
  // decode
  atf_host_decode u_dec
  (
    .i_addr     ({i_host.cs2, i_host.cs1, i_host.da}),
    .o_data     (s_data),
    .o_feat_err (s_feat_err),
    .o_intr     (s_intr),
    .o_sect     (s_sect),
    .o_bcl      (s_bcl),
    .o_bch      (s_bch),
    .o_drvsel   (s_drvsel),
    .o_cmd_stat (s_cmd_stat),
    .o_dctl_alt (s_dctl_alt),
    .o_drvadr   (s_drvadr)
  );

  // ==========================================================================
  // helpers
  function automatic logic [15:0] atf_byte(input logic [7:0] b);
    atf_byte = {atf_pkg::BYTE_ZERO, b};
  endfunction : atf_byte

  // status with the busy flag forced, other bits untouched
  function automatic logic [7:0] atf_busy(input logic [7:0] s, input logic b);
    atf_busy                        = s;
    atf_busy[atf_pkg::BUSY_BIT_POS] = b;
  endfunction : atf_busy

  // reset image: busy raised and the fixed drive-select bits in place
  function automatic atf_state_t atf_reset_state();
    atf_state_t s;
    s                = '0;
    s.shared.status  = atf_pkg::STATUS_RST;
    s.drive_selector = atf_pkg::DRVSEL_FIXED;
    atf_reset_state  = s;
  endfunction : atf_reset_state

  // combinational compare, so a drive-select write takes effect at once
  assign selected = (st_reg.drive_selector[atf_pkg::DRV_BIT_POS] == i_own_drive_number);
  assign host_cs  = i_host.cs1 | i_host.cs2;
  // strobes held several cycles act once, on their leading edge
  assign wr_evt   = i_host.wr & ~st_reg.wr_prev & host_cs;
  assign rd_evt   = i_host.rd & ~st_reg.rd_prev & host_cs;
  // diagnostic code is acted on even by the drive that is not selected
  assign cmd_accept = selected | (i_host.wdata[7:0] == atf_pkg::CMD_DIAG);

  // ==========================================================================
  // next state
  always_comb
  begin
    st_next          = st_reg;
    st_next.rd_prev  = i_host.rd;
    st_next.wr_prev  = i_host.wr;
    st_next.cmd_irq  = 1'b0;
    st_next.soft_reset_bit_irq = 1'b0;
    st_next.data_wr  = 1'b0;
    st_next.data_rd  = 1'b0;

    // sub-cpu updates first; host writes to the same register override
    if (i_cpu_wr)
    begin
      st_next.shared = i_cpu_regs;
    end
    if (i_cpu_busy_clr)
    begin
      st_next.shared.status = atf_busy(st_next.shared.status, 1'b0);
    end

    if (wr_evt)
    begin
      if (s_data)
      begin
        st_next.shared.data = i_host.wdata;
        st_next.data_wr     = 1'b1;
      end
      else if (s_feat_err)
      begin
        st_next.feature_code = i_host.wdata[7:0];
      end
      else if (s_intr)
      begin
        st_next.shared.interrupt_reason = i_host.wdata[7:0];
      end
      else if (s_sect)
      begin
        st_next.shared.sector_count = i_host.wdata[7:0];
      end
      else if (s_bcl)
      begin
        st_next.shared.byte_count_low = i_host.wdata[7:0];
      end
      else if (s_bch)
      begin
        st_next.shared.byte_count_high = i_host.wdata[7:0];
      end
      else if (s_drvsel)
      begin
        st_next.drive_selector = atf_pkg::DRVSEL_FIXED | (i_host.wdata[7:0] & atf_pkg::DRVSEL_KEEP);
      end
      else if (s_cmd_stat)
      begin
        st_next.command_entry = i_host.wdata[7:0];
        st_next.irq_pending   = 1'b0;
        if (cmd_accept)
        begin
          st_next.cmd_irq = 1'b1;
          st_next.shared.status = atf_busy(st_next.shared.status, 1'b1);
        end
      end
      else if (s_dctl_alt)
      begin
        st_next.device_control = i_host.wdata[7:0];
        if (i_host.wdata[atf_pkg::SOFT_RESET_BIT_BIT_POS])
        begin
          st_next.soft_reset_bit_irq = 1'b1;
          st_next.shared.status = atf_busy(st_next.shared.status, 1'b1);
        end
      end
    end

    // a status read negates the host interrupt; alternate status does not
    if (rd_evt && s_cmd_stat)
    begin
      st_next.irq_pending = 1'b0;
    end
    // a new request from the sub-cpu wins over a same-cycle clear
    if (i_cpu_irq_set && selected)
    begin
      st_next.irq_pending = 1'b1;
    end

    // read data, held for as long as the strobe is held
    st_next.rsp = '0;
    if (i_host.rd && host_cs)
    begin
      st_next.rsp.rdata_oe = atf_pkg::OE_BYTE;
      if (s_data)
      begin
        st_next.rsp.rdata    = st_reg.shared.data;
        st_next.rsp.rdata_oe = atf_pkg::OE_WORD;
        st_next.data_rd      = rd_evt;
      end
      else if (s_feat_err)
      begin
        st_next.rsp.rdata = atf_byte(st_reg.shared.error_report);
      end
      else if (s_intr)
      begin
        st_next.rsp.rdata = atf_byte(st_reg.shared.interrupt_reason);
      end
      else if (s_sect)
      begin
        st_next.rsp.rdata = atf_byte(st_reg.shared.sector_count);
      end
      else if (s_bcl)
      begin
        st_next.rsp.rdata = atf_byte(st_reg.shared.byte_count_low);
      end
      else if (s_bch)
      begin
        st_next.rsp.rdata = atf_byte(st_reg.shared.byte_count_high);
      end
      else if (s_drvsel)
      begin
        st_next.rsp.rdata = atf_byte(st_reg.drive_selector);
      end
      else if (s_cmd_stat || s_dctl_alt)
      begin
        st_next.rsp.rdata = atf_byte(st_reg.shared.status);
      end
      else if (s_drvadr)
      begin
        st_next.rsp.rdata = atf_byte(st_reg.shared.drive_address);
        st_next.rsp.rdata_oe[atf_pkg::HIZ_BIT_POS] = 1'b0;
      end
      else
      begin
        st_next.rsp.rdata_oe = atf_pkg::WORD_ZERO;
      end
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      st_reg <= atf_reset_state();
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // host interrupt pin
  atf_irq_pin u_irq
  (
    .i_sys_clk  (i_sys_clk),
    .i_rst      (i_rst),
    .i_pending  (st_reg.irq_pending),
    .i_disable  (st_reg.device_control[atf_pkg::HOST_IRQ_DISABLE_BIT_POS]),
    .i_selected (selected),
    .o_irq_out  (o_irq_out),
    .o_irq_oe   (o_irq_oe)
  );

  assign o_host                = st_reg.rsp;
  assign o_cpu_regs            = st_reg.shared;
  assign o_feature_code        = st_reg.feature_code;
  assign o_command_entry       = st_reg.command_entry;
  assign o_drive_selector      = st_reg.drive_selector;
  assign o_device_control      = st_reg.device_control;
  assign o_command_arrival_irq = st_reg.cmd_irq;
  assign o_soft_reset_irq      = st_reg.soft_reset_bit_irq;
  assign o_data_wr_pulse       = st_reg.data_wr;
  assign o_data_rd_pulse       = st_reg.data_rd;

endmodule : atf_task_file
`default_nettype wire

// File: verification/atf_host_model.sv
// host adapter model: runs task-file cycles on the parallel host port
`timescale 1ns/1ps
`default_nettype none
module atf_host_model
(
  input  wire logic                   i_sys_clk,
  output atf_pkg::atf_host_req_t      o_req,
  input  wire atf_pkg::atf_host_rsp_t i_rsp
);
  // ==========================================================================
  // bus cycles
  initial o_req = '0;

  // released data lines are inverted so a stale value never looks valid
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge i_sys_clk);
    o_req <= {a[3], a[4], a[2:0], 2'b01, v};
    @(posedge i_sys_clk);
    o_req <= {7'h00, ~v};
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] v, output logic [15:0] oe);
    @(posedge i_sys_clk);
    o_req <= {a[3], a[4], a[2:0], 2'b10, ~o_req.wdata};
    repeat (2) @(posedge i_sys_clk);
    v = i_rsp.rdata;
    oe = i_rsp.rdata_oe;
    o_req <= {7'h00, ~o_req.wdata};
  endtask : rd
endmodule : atf_host_model
`default_nettype wire

// File: verification/atf_task_file_chk.sv
// checker: host-port relations of the task-file block
`timescale 1ns/1ps
`default_nettype none
module atf_task_file_chk
(
  input wire logic                   i_sys_clk,
  input wire logic                   i_rst,
  input wire atf_pkg::atf_host_req_t i_host,
  input wire atf_pkg::atf_host_rsp_t o_host,
  input wire logic                   o_irq_out,
  input wire logic                   o_irq_oe,
  input wire logic                   i_own_drive_number,
  input wire logic                   i_cpu_irq_set,
  input wire logic                   i_cpu_busy_clr,
  input wire atf_pkg::atf_cpu_regs_t o_cpu_regs,
  input wire logic [7:0]             o_drive_selector,
  input wire logic [7:0]             o_device_control,
  input wire logic                   o_command_arrival_irq,
  input wire logic                   o_soft_reset_irq
);
  // ==========================================================================
  // helper logic
  logic       wr_q;
  logic       wre;
  logic       cmd;
  logic       sel;
  logic       en;
  logic       diag;
  logic [4:0] a;
  always_ff @(posedge i_sys_clk) wr_q <= i_rst ? 1'b0 : i_host.wr;
  assign a    = {i_host.cs2, i_host.cs1, i_host.da};
  assign wre  = i_host.wr & ~wr_q & (i_host.cs1 | i_host.cs2);
  assign cmd  = wre && a == atf_pkg::ADDR_CMD_STAT;
  assign diag = i_host.wdata[7:0] == atf_pkg::CMD_DIAG;
  assign sel  = o_drive_selector[4] == i_own_drive_number;
  assign en   = sel & ~o_device_control[1];
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // ==========================================================================
  // assertions
  cmd_sel_a : assert property (cmd && sel && !i_cpu_busy_clr |=> o_command_arrival_irq && o_cpu_regs.status[7])
    else $error("selected command gave no arrival pulse or busy");
  cmd_diag_a : assert property (cmd && diag && !i_cpu_busy_clr |=> o_command_arrival_irq && o_cpu_regs.status[7])
    else $error("diagnostic command gave no arrival pulse or busy");
  cmd_unsel_a : assert property (cmd && !sel && !diag |=> !o_command_arrival_irq)
    else $error("unselected command raised arrival pulse");
  soft_reset_bit_busy_a : assert property (wre && a == atf_pkg::ADDR_DCTL_ALT && i_host.wdata[2] && !i_cpu_busy_clr
    |=> o_soft_reset_irq && o_cpu_regs.status[7])
    else $error("soft reset write gave no pulse or busy");
  // the pending flag clears one edge after the write and the pin follows one edge later
  cmd_clear_a : assert property (cmd && !i_cpu_irq_set |-> ##2 !o_irq_out)
    else $error("command write left host interrupt set");
  alt_keep_a : assert property (o_irq_out && i_host.rd && a == atf_pkg::ADDR_DCTL_ALT |=> o_irq_out)
    else $error("alternate status read dropped host interrupt");
  adr_hiz_a : assert property (i_host.rd && a == atf_pkg::ADDR_DRVADR |=> o_host.rdata_oe == 16'h007f)
    else $error("drive address read drove bit 7");
  pin_on_a : assert property (en [*3] |-> o_irq_oe)
    else $error("interrupt pin not enabled");
  pin_off_a : assert property (!en [*3] |-> !o_irq_oe)
    else $error("interrupt pin driven while disabled");
endmodule : atf_task_file_chk

bind atf_task_file atf_task_file_chk u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_host(i_host),
  .o_host(o_host), .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe), .i_own_drive_number(i_own_drive_number),
  .i_cpu_irq_set(i_cpu_irq_set), .i_cpu_busy_clr(i_cpu_busy_clr), .o_cpu_regs(o_cpu_regs),
  .o_drive_selector(o_drive_selector), .o_device_control(o_device_control),
  .o_command_arrival_irq(o_command_arrival_irq), .o_soft_reset_irq(o_soft_reset_irq));
`default_nettype wire

// File: verification/tb_atf_task_file.sv
// testbench: task-file register port scenarios through the host model
`timescale 1ns/1ps
`default_nettype none
module tb_atf_task_file;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   own = 1'b0;
  logic                   cwr = 1'b0;
  logic                   iset = 1'b0;
  logic                   bclr = 1'b0;
  atf_pkg::atf_cpu_regs_t cin = '0;
  atf_pkg::atf_cpu_regs_t cout;
  atf_pkg::atf_host_req_t req;
  atf_pkg::atf_host_rsp_t rsp;
  logic                   irq;
  logic                   oe;
  logic                   cai;
  logic                   sri;
  logic                   dwr;
  logic                   drd;
  logic [7:0]             cmde;
  logic [7:0]             dsel;
  logic [7:0]             dctl;
  logic [7:0]             feat;
  logic [15:0]            d;
  logic [15:0]            e;
  int                     error_cnt = 0;
  int                     num_checks = 0;
  int                     n_cai = 0;
  int                     n_sri = 0;
  int                     n_dwr = 0;
  int                     n_drd = 0;
  int                     cyc = 0;

  atf_host_model host (.i_sys_clk(clk), .o_req(req), .i_rsp(rsp));
  atf_task_file dut (.i_sys_clk(clk), .i_rst(rst), .i_host(req), .o_host(rsp), .o_irq_out(irq), .o_irq_oe(oe),
    .i_own_drive_number(own), .i_cpu_wr(cwr), .i_cpu_regs(cin), .i_cpu_irq_set(iset), .i_cpu_busy_clr(bclr),
    .o_cpu_regs(cout), .o_feature_code(feat), .o_command_entry(cmde), .o_drive_selector(dsel),
    .o_device_control(dctl), .o_command_arrival_irq(cai), .o_soft_reset_irq(sri), .o_data_wr_pulse(dwr),
    .o_data_rd_pulse(drd));

  // ==========================================================================
  // clock, pulse counters and hang guard
  initial forever #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    n_cai <= n_cai + int'(cai === 1'b1);
    n_sri <= n_sri + int'(sri === 1'b1);
    n_dwr <= n_dwr + int'(dwr === 1'b1);
    n_drd <= n_drd + int'(drd === 1'b1);
    if (cyc == 3000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  // ==========================================================================
  // shared tasks
  task automatic stop_test;
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      error_cnt++;
  endtask : chk

  // outputs are registered, so look well after the launching edge
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask : settle

  task automatic cpu(input logic w, input logic s, input logic b);
    @(posedge clk);
    {cwr, iset, bclr} <= {w, s, b};
    @(posedge clk);
    {cwr, iset, bclr} <= 3'b000;
    settle();
  endtask : cpu

  task automatic hw(input logic [4:0] a, input logic [15:0] v);
    host.wr(a, v);
    settle();
  endtask : hw

  task automatic cmd_case(input logic [15:0] v, input logic [15:0] exp);
    int n;
    cpu(1'b0, 1'b0, 1'b1);
    n = n_cai;
    hw(atf_pkg::ADDR_CMD_STAT, v);
    chk(16'(n_cai - n), exp);
    chk(16'(cout.status[7]), exp);
    chk(16'(cmde), v);
  endtask : cmd_case

  // ==========================================================================
  // scenarios
  task automatic t_regs;
    @(posedge clk);
    cin <= {16'hbeef, 8'h41, 8'h03, 8'h5a, 8'h00, 8'h02, 8'h00, 8'hff};
    cpu(1'b1, 1'b0, 1'b0);
    host.rd(atf_pkg::ADDR_DATA, d, e);
    chk(d, 16'hbeef);
    chk(e, 16'hffff);
    hw(atf_pkg::ADDR_DATA, 16'h1234);
    chk(cout.data, 16'h1234);
    chk(16'(n_dwr), 16'h0001);
    chk(16'(n_drd), 16'h0001);
    hw(atf_pkg::ADDR_SECT, 16'h003c);
    chk(16'(cout.sector_count), 16'h003c);
    host.rd(atf_pkg::ADDR_SECT, d, e);
    chk({e[15:8], d[7:0]}, 16'h003c);
    host.rd(atf_pkg::ADDR_FEAT_ERR, d, e);
    chk({e[15:8], d[7:0]}, 16'h0041);
    host.rd(atf_pkg::ADDR_DRVADR, d, e);
    chk(e, 16'h007f);
    chk(16'(d[6:0]), 16'h007f);
    host.rd(5'h08, d, e);
    chk(e, 16'h0000);
    hw(atf_pkg::ADDR_FEAT_ERR, 16'h0077);
    chk(16'(feat), 16'h0077);
  endtask : t_regs

  task automatic t_cmd;
    hw(atf_pkg::ADDR_DRVSEL, 16'h0000);
    chk(16'(dsel), 16'h00e0);
    cmd_case(16'h00a0, 16'h0001);
    hw(atf_pkg::ADDR_DRVSEL, 16'h0010);
    cmd_case(16'h00a0, 16'h0000);
    cmd_case(16'h0090, 16'h0001);
    hw(atf_pkg::ADDR_DRVSEL, 16'h0000);
  endtask : t_cmd

  task automatic t_irq;
    hw(atf_pkg::ADDR_DCTL_ALT, 16'h0000);
    cpu(1'b0, 1'b1, 1'b0);
    chk({14'h0000, irq, oe}, 16'h0003);
    host.rd(atf_pkg::ADDR_DCTL_ALT, d, e);
    chk({e[15:8], d[7:0]}, 16'h0080);
    chk(16'(irq), 16'h0001);
    hw(atf_pkg::ADDR_DCTL_ALT, 16'h0002);
    chk(16'(dctl), 16'h0002);
    chk(16'(oe), 16'h0000);
    hw(atf_pkg::ADDR_DCTL_ALT, 16'h0000);
    @(posedge clk);
    own <= 1'b1;
    settle();
    chk(16'(oe), 16'h0000);
    @(posedge clk);
    own <= 1'b0;
    settle();
    chk(16'(oe), 16'h0001);
    hw(atf_pkg::ADDR_CMD_STAT, 16'h00a0);
    chk(16'(irq), 16'h0000);
  endtask : t_irq

  task automatic t_soft_reset_bit;
    int n;
    cpu(1'b0, 1'b0, 1'b1);
    n = n_sri;
    hw(atf_pkg::ADDR_DCTL_ALT, 16'h0004);
    chk(16'(n_sri - n), 16'h0001);
    chk(16'(cout.status[7]), 16'h0001);
  endtask : t_soft_reset_bit

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk(16'(cout.status), 16'h0080);
    chk(16'(dsel), 16'h00e0);
    t_regs();
    t_cmd();
    t_irq();
    t_soft_reset_bit();
    stop_test();
  end
endmodule : tb_atf_task_file
`default_nettype wire
